// ### hdl/ccc_top.v
// Purpose: digital chopper sequencing for both coils of a bipolar stepper
// Assumes: comparator inputs are asynchronous pins; settings come from
//          logic on clk_sys
// Notes:   one generate lane per coil, lanes share only settings
`include "ccc_defs.vh"

module ccc_top #(
  parameter NCOIL = 2
) (
  // clock and reset
  input  wire                 clk_sys,
  input  wire                 resetn,
  // chopper settings
  input  wire [3:0]           off_time_setting,
  input  wire [1:0]           blank_time_select,
  input  wire                 chopper_algorithm_select,
  input  wire [2:0]           hysteresis_start_offset,
  input  wire [3:0]           hysteresis_end_value,
  input  wire [1:0]           hysteresis_decrement_rate,
  input  wire [3:0]           fast_decay_duration,
  // current comparators, one per coil (async pins)
  input  wire [NCOIL-1:0]     comp_trip,
  // bridge control, one bit per coil
  output wire [NCOIL-1:0]     bridge_drive_on,
  output wire [NCOIL-1:0]     bridge_fast_decay,
  output wire [NCOIL-1:0]     bridge_slow_decay,
  // status: phase code and signed hysteresis, 3 and 6 bits per coil
  output wire [3*NCOIL-1:0]   chop_phase,
  output wire [6*NCOIL-1:0]   hyst_level
);

  // ----------------------------------------------------------------
  // shared decodes
  // ----------------------------------------------------------------
  wire       chop_en   = (off_time_setting != 4'h0);
  wire       mode_hyst = (chopper_algorithm_select == `CCC_MODE_HYST);
  // slow decay load: setting*32+12, minus one for a down-count to zero
  wire [9:0] off_load  = ({6'h00, off_time_setting} << `CCC_OFF_SHIFT)
                         + `CCC_OFF_ADD - 10'h001;
  wire [9:0] fd_load   = ({6'h00, fast_decay_duration} << `CCC_FD_SHIFT)
                         - 10'h001;
  wire       fd_skip   = (fast_decay_duration == 4'h0);
  // hysteresis start = (offset+1) + (end-3); end = end-3
  wire [5:0] hyst_end  = {2'h0, hysteresis_end_value} - `CCC_HYSTERESIS_END_VALUE_SUB;
  wire [5:0] hyst_strt = {3'h0, hysteresis_start_offset} + `CCC_HYSTERESIS_START_OFFSET_ADD
                         + hyst_end;
  // decrement period 16 * (rate + 1)
  wire [6:0] dec_per   = `CCC_DEC_BASE * ({5'h00, hysteresis_decrement_rate}
                         + 7'h01);

  genvar g;
  generate
    for (g = 0; g < NCOIL; g = g + 1) begin : coil
      // per-lane state
      reg        sync1_r;   // comparator sync stage one
      reg        sync2_r;   // comparator sync stage two
      reg  [2:0] st_r;      // chopper phase
      reg  [2:0] st_nxt;
      reg  [9:0] cnt_r;     // phase timer, counts down to zero
      reg  [9:0] cnt_nxt;
      reg  [6:0] div_r;     // hysteresis decrement divider
      reg  [5:0] hyst_r;    // signed hysteresis value
      reg        on_r;      // bridge drive flops
      reg        fd_r;
      reg        sd_r;
      wire       blank;     // comparator mask
      wire       trip;      // qualified comparator event
      wire       sw;        // bridge transition this edge

      // ------------------------------------------------------------
      // comparator synchroniser
      // ------------------------------------------------------------
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          sync1_r <= 1'b0;
          sync2_r <= 1'b0;
        end else begin
          sync1_r <= comp_trip[g];
          sync2_r <= sync1_r;
        end
      end

      assign trip = sync2_r & ~blank;
      assign sw   = (st_nxt != st_r);

      // blanking restarts on every transition
      ccc_blank_timer u_blank (
        .clk_sys           (clk_sys),
        .resetn            (resetn),
        .restart           (sw),
        .blank_time_select (blank_time_select),
        .blank_active_r    (blank)
      );

      // ------------------------------------------------------------
      // phase sequencing
      // ------------------------------------------------------------
      always @* begin
        st_nxt  = st_r;
        cnt_nxt = (cnt_r != 10'h000) ? cnt_r - 10'h001 : cnt_r;
        if (!chop_en) begin
          st_nxt  = `CCC_ST_OFF;
          cnt_nxt = 10'h000;
        end else begin
          case (st_r)
            `CCC_ST_OFF: begin
              st_nxt = `CCC_ST_ON;
            end
            `CCC_ST_ON: begin
              if (trip) begin
                if (mode_hyst) begin
                  st_nxt  = `CCC_ST_SD1;
                  cnt_nxt = off_load;
                end else if (fd_skip) begin
                  st_nxt  = `CCC_ST_SD2;
                  cnt_nxt = off_load;
                end else begin
                  st_nxt  = `CCC_ST_FD;
                  cnt_nxt = fd_load;
                end
              end
            end
            `CCC_ST_SD1: begin
              if (cnt_r == 10'h000) begin
                st_nxt = `CCC_ST_FD;
              end
            end
            `CCC_ST_FD: begin
              // hysteresis: comparator ends it; else the fast timer
              if ((mode_hyst && trip) ||
                  (!mode_hyst && cnt_r == 10'h000)) begin
                st_nxt  = `CCC_ST_SD2;
                cnt_nxt = off_load;
              end
            end
            `CCC_ST_SD2: begin
              if (cnt_r == 10'h000) begin
                st_nxt = `CCC_ST_ON;
              end
            end
            default: begin
              st_nxt = `CCC_ST_OFF;
            end
          endcase
        end
      end

      // state, timer and bridge drive flops
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          st_r  <= `CCC_ST_OFF;
          cnt_r <= 10'h000;
          on_r  <= 1'b0;
          fd_r  <= 1'b0;
          sd_r  <= 1'b0;
        end else begin
          st_r  <= st_nxt;
          cnt_r <= cnt_nxt;
          on_r  <= (st_nxt == `CCC_ST_ON);
          fd_r  <= (st_nxt == `CCC_ST_FD);
          sd_r  <= (st_nxt == `CCC_ST_SD1) || (st_nxt == `CCC_ST_SD2);
        end
      end

      // ------------------------------------------------------------
      // hysteresis decrementer
      // ------------------------------------------------------------
      // reload at each cycle start, step down to the end value
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          div_r  <= 7'h00;
          hyst_r <= 6'h00;
        end else if (sw && st_nxt == `CCC_ST_ON) begin
          div_r  <= 7'h00;
          hyst_r <= hyst_strt;
        end else if (mode_hyst && st_r != `CCC_ST_OFF) begin
          if (div_r >= dec_per - 7'h01) begin
            div_r <= 7'h00;
            if ($signed(hyst_r) > $signed(hyst_end)) begin
              hyst_r <= hyst_r - 6'h01;
            end
          end else begin
            div_r <= div_r + 7'h01;
          end
        end
      end

      // ------------------------------------------------------------
      // outputs
      // ------------------------------------------------------------
      assign bridge_drive_on[g]    = on_r;
      assign bridge_fast_decay[g]  = fd_r;
      assign bridge_slow_decay[g]  = sd_r;
      assign chop_phase[3*g +: 3]  = st_r;
      assign hyst_level[6*g +: 6]  = hyst_r;
    end
  endgenerate

endmodule // ccc_top

// ### hdl/ccc_defs.vh
// Purpose: constants for the two-coil current chopper
// Assumes: 10 MHz clk_sys; all counts are in system clock cycles
// Notes:   guarded header, definitions only
//
// What this block does
// - Two independent choppers, one per coil
// - Slow decay always ends by timer
// - On phase ends on comparator trip
// - Fast decay ends by comparator or timer
// - Comparator masked during blanking after switching
// - Constant off-time: on, fast, slow decay
// - Hysteresis mode: on, slow, fast, slow
// - Off-time zero: all bridge switches off
// - Slow decay lasts setting*32+12 cycles
// - Blanking select: 16, 24, 36, 54 cycles
// - Mode bit: 0 hysteresis, 1 constant off-time
// - Hysteresis mode: fast decay length from comparator
// - Hysteresis start enforces minimum current ripple
// - Hysteresis decrements every 16/32/48/64 cycles
// - Cycle start loads start+end, decrements to end
// - Constant off-time fast setting 0 skips fast
`ifndef CCC_DEFS_VH
`define CCC_DEFS_VH

// ----------------------------------------------------------------
// chopper phase codes
// ----------------------------------------------------------------
`define CCC_ST_OFF    3'h0
`define CCC_ST_ON     3'h1
`define CCC_ST_SD1    3'h2
`define CCC_ST_FD     3'h3
`define CCC_ST_SD2    3'h4

// ----------------------------------------------------------------
// timing counts (cycles)
// ----------------------------------------------------------------
`define CCC_OFF_SHIFT 5
`define CCC_OFF_ADD   10'h00c
`define CCC_FD_SHIFT  5
`define CCC_BLANK_0   6'h10
`define CCC_BLANK_1   6'h18
`define CCC_BLANK_2   6'h24
`define CCC_BLANK_3   6'h36
`define CCC_DEC_BASE  7'h10

// ----------------------------------------------------------------
// hysteresis setting offsets and hysteresis mode code
// ----------------------------------------------------------------
`define CCC_HYSTERESIS_START_OFFSET_ADD 6'h01
`define CCC_HYSTERESIS_END_VALUE_SUB  6'h03
`define CCC_MODE_HYST 1'b0

`endif

// ### hdl/ccc_blank_timer.v
// Purpose: blanking window timer for one coil's current comparator
// Assumes: restart is a one-cycle pulse on every bridge transition
// Notes:   select is sampled only at restart
`include "ccc_defs.vh"

module ccc_blank_timer (
  // clock and reset
  input  wire       clk_sys,
  input  wire       resetn,
  // control
  input  wire       restart,
  input  wire [1:0] blank_time_select,
  // status
  output reg        blank_active_r
);

  // ----------------------------------------------------------------
  // blank length decode
  // ----------------------------------------------------------------
  reg  [5:0] cnt_r;   // remaining blank cycles minus one
  reg  [5:0] len;     // selected blank length

  // map select code to cycle count
  always @* begin
    case (blank_time_select)
      2'h0:    len = `CCC_BLANK_0;
      2'h1:    len = `CCC_BLANK_1;
      2'h2:    len = `CCC_BLANK_2;
      default: len = `CCC_BLANK_3;
    endcase
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // restart wins; mask stays high for exactly len cycles
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_r          <= 6'h00;
      blank_active_r <= 1'b0;
    end else if (restart) begin
      cnt_r          <= len - 6'h01;
      blank_active_r <= 1'b1;
    end else if (cnt_r != 6'h00) begin
      cnt_r          <= cnt_r - 6'h01;
    end else begin
      blank_active_r <= 1'b0;
    end
  end

endmodule // ccc_blank_timer

// ### dv/ccc_sva.sv
// Purpose: port checker for the two-coil chopper, watching coil 0
// Assumes: settings change only while off_time_setting is 0
// Notes:   bound into ccc_top after the module
`include "ccc_defs.vh"
module ccc_sva #(parameter NCOIL = 2) (
  // clock, reset and settings
  input logic clk_sys, resetn, chopper_algorithm_select,
  input logic [3:0] off_time_setting, hysteresis_end_value, fast_decay_duration,
  input logic [2:0] hysteresis_start_offset,
  input logic [1:0] blank_time_select,
  // coil side
  input logic [NCOIL-1:0] comp_trip, bridge_drive_on, bridge_fast_decay, bridge_slow_decay,
  input logic [3*NCOIL-1:0] chop_phase,
  input logic [6*NCOIL-1:0] hyst_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ph_r;   // phase one cycle ago
  logic [11:0] cnt_r; // cycles spent in ph_r
  wire [2:0] ph = chop_phase[2:0];
  wire run = off_time_setting != 4'h0;
  wire chg = run && ph != ph_r;
  wire cot = chopper_algorithm_select;
  wire [5:0] lo = {2'h0, hysteresis_end_value} - 6'h03; // hysteresis end value
  wire [5:0] blk = blank_time_select[1] ? (blank_time_select[0] ? 6'h36 : 6'h24)
                 : (blank_time_select[0] ? 6'h18 : 6'h10);
  // previous phase and its length
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ph_r <= 3'h0;
      cnt_r <= 12'h000;
    end else begin
      ph_r <= ph;
      cnt_r <= (ph != ph_r) ? 12'h001 : cnt_r + 12'h001;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  chk_off_freewheel: assert property (
    !run |=> {bridge_drive_on[0], bridge_fast_decay[0], bridge_slow_decay[0]} == 3'h0)
    else $error("bridge not released");
  chk_off_wakeup: assert property (
    run && ph == `CCC_ST_OFF |=> ph == `CCC_ST_ON) else $error("no restart");
  chk_bridge_map: assert property (
    bridge_drive_on[0] == (ph == `CCC_ST_ON) && bridge_fast_decay[0] == (ph == `CCC_ST_FD)
    && bridge_slow_decay[0] == (ph == `CCC_ST_SD1 || ph == `CCC_ST_SD2)) else $error("map");
  chk_slow_len: assert property (
    chg && (ph_r == `CCC_ST_SD1 || ph_r == `CCC_ST_SD2)
    |-> cnt_r == {3'h0, off_time_setting, 5'h00} + 12'h00c) else $error("slow length");
  chk_on_blank: assert property (
    chg && ph_r == `CCC_ST_ON |-> cnt_r > {6'h00, blk}) else $error("on ended in blanking");
  chk_on_trip: assert property (
    chg && ph_r == `CCC_ST_ON |-> $past(comp_trip[0], 2) || $past(comp_trip[0], 3))
    else $error("on ended without trip");
  chk_cot_fast: assert property (
    chg && cot && ph_r == `CCC_ST_FD |-> cnt_r == {3'h0, fast_decay_duration, 5'h00})
    else $error("fast length");
  chk_cot_order: assert property (
    chg && cot |-> ph == (ph_r != `CCC_ST_ON ? (ph_r == `CCC_ST_FD ? `CCC_ST_SD2 : `CCC_ST_ON)
    : fast_decay_duration != 4'h0 ? `CCC_ST_FD : `CCC_ST_SD2)) else $error("cot order");
  chk_hyst_order: assert property (
    chg && !cot |-> ph == (ph_r == `CCC_ST_ON ? `CCC_ST_SD1 : ph_r == `CCC_ST_SD1 ? `CCC_ST_FD
    : ph_r == `CCC_ST_FD ? `CCC_ST_SD2 : `CCC_ST_ON)) else $error("hyst order");
  chk_hyst_load: assert property (
    chg && !cot && ph == `CCC_ST_ON |-> hyst_level[5:0] ==
    {3'h0, hysteresis_start_offset} + 6'h01 + lo) else $error("hyst start");
  chk_hyst_floor: assert property (
    run && !cot && ph != `CCC_ST_OFF && ph_r != `CCC_ST_OFF
    |-> $signed(hyst_level[5:0]) >= $signed(lo)) else $error("hyst below end");
  cov_cot: cover property (chg && cot && ph_r == `CCC_ST_FD);
  cov_hyst: cover property (chg && !cot && ph_r == `CCC_ST_SD2);
  cov_wake: cover property (!run ##1 run);
endmodule // ccc_sva

bind ccc_top ccc_sva #(.NCOIL(NCOIL)) i_ccc_sva (.*);

// ### dv/ccc_coil_model.sv
// Purpose: bridge and sense comparator model for one coil
// Assumes: current is sensed only in on and fast decay
// Notes:   spike_en adds a switching spike after transitions
module ccc_coil_model (
  // clock and reset
  input  logic       clk_sys,
  input  logic       resetn,
  // bridge state and knobs
  input  logic       drive_on,
  input  logic       fast_decay,
  input  logic       spike_en,
  input  logic [7:0] rise,
  // comparator output
  output logic       comp_trip
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] t_r;  // cycles since the bridge switched
  logic [1:0] br_r; // bridge state last cycle
  wire  [1:0] br = {drive_on, fast_decay};
  // ramps up while on, falls in fast decay, unseen in slow decay
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      t_r <= 8'h00;
      br_r <= 2'h0;
      comp_trip <= 1'b0;
    end else begin
      br_r <= br;
      t_r <= (br != br_r) ? 8'h00 : (t_r == 8'hff ? t_r : t_r + 8'h01);
      comp_trip <= (spike_en && br != 2'h0 && t_r < 8'h03) || (drive_on && t_r >= rise)
                   || (fast_decay && t_r >= {1'b0, rise[7:1]});
    end
  end
endmodule // ccc_coil_model

// ### dv/test_coil_current_chopper.sv
// Purpose: self-checking bench for the two-coil chopper
// Assumes: settings change only through off time 0
// Notes:   coil models close the current loop
`include "ccc_defs.vh"
module test_coil_current_chopper;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, resetn = 1'b0, set_mode = 1'b0, spike = 1'b0;
  logic [3:0] set_off = 4'h0, set_hnd = 4'h6, set_fd = 4'h0;
  logic [2:0] set_hst = 3'h3;
  logic [1:0] set_blk = 2'h0, set_hdr = 2'h0;
  logic [7:0] rise0 = 8'h3c;
  wire [1:0] trip, drv, fst, slw;
  wire [5:0] phase;
  wire [11:0] hyst;
  int error_cnt = 0, n_checks = 0;
  ccc_top i_ccc_top (.clk_sys(clk_sys), .resetn(resetn), .off_time_setting(set_off),
    .blank_time_select(set_blk), .chopper_algorithm_select(set_mode),
    .hysteresis_start_offset(set_hst), .hysteresis_end_value(set_hnd),
    .hysteresis_decrement_rate(set_hdr), .fast_decay_duration(set_fd), .comp_trip(trip),
    .bridge_drive_on(drv), .bridge_fast_decay(fst), .bridge_slow_decay(slw),
    .chop_phase(phase), .hyst_level(hyst));
  ccc_coil_model i_ccc_coil_model0 (.clk_sys(clk_sys), .resetn(resetn), .drive_on(drv[0]),
    .fast_decay(fst[0]), .spike_en(spike), .rise(rise0), .comp_trip(trip[0]));
  ccc_coil_model i_ccc_coil_model1 (.clk_sys(clk_sys), .resetn(resetn), .drive_on(drv[1]),
    .fast_decay(fst[1]), .spike_en(spike), .rise(8'h5a), .comp_trip(trip[1]));
  task automatic cmp(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic cmp_ph(input int c, input logic [2:0] p);
    cmp("phase", {9'h000, p}, {9'h000, phase[3*c+:3]});
  endtask
  // wait at falling edges until coil c shows phase p
  task automatic wait_ph(input int c, input logic [2:0] p);
    for (int k = 0; k < 3000 && phase[3*c+:3] !== p; k++) @(negedge clk_sys);
    cmp_ph(c, p);
  endtask
  // count cycles until coil c leaves its phase
  task automatic ph_len(input int c, output int n);
    logic [2:0] p;
    p = phase[3*c+:3];
    for (n = 0; n < 4000 && phase[3*c+:3] === p; n++) @(negedge clk_sys);
  endtask
  // stop the chopper, check freewheel, then apply new settings
  task automatic cfg(input logic [3:0] off, input logic [1:0] blk, input logic md,
                     input logic [3:0] fd);
    @(posedge clk_sys);
    set_off <= 4'h0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    cmp("bridges", 12'h000, {6'h00, drv, fst, slw});
    @(posedge clk_sys);
    set_blk <= blk;
    set_hdr <= blk;
    set_mode <= md;
    set_fd <= fd;
    set_off <= off;
    @(negedge clk_sys);
  endtask
  task automatic t_cot;
    int n;
    cfg(4'h1, 2'h1, 1'b1, 4'h1);
    for (int c = 0; c < 2; c++) begin
      wait_ph(c, `CCC_ST_FD);
      ph_len(c, n);
      cmp("fast len", 12'h020, n[11:0]);
      cmp_ph(c, `CCC_ST_SD2);
      ph_len(c, n);
      cmp("slow len", 12'h02c, n[11:0]);
      cmp_ph(c, `CCC_ST_ON);
    end
  endtask
  task automatic t_nofd;
    int n;
    cfg(4'hf, 2'h0, 1'b1, 4'h0);
    wait_ph(0, `CCC_ST_ON);
    ph_len(0, n);
    cmp_ph(0, `CCC_ST_SD2);
    ph_len(0, n);
    cmp("slow len", 12'h1ec, n[11:0]);
  endtask
  task automatic t_hyst;
    int n;
    cfg(4'h2, 2'h3, 1'b0, 4'h0);
    wait_ph(0, `CCC_ST_ON);
    cmp("hyst start", 12'h007, {6'h00, hyst[5:0]});
    cmp("hyst start 1", 12'h007, {6'h00, hyst[11:6]});
    wait_ph(0, `CCC_ST_SD1);
    ph_len(0, n);
    cmp("slow1 len", 12'h04c, n[11:0]);
    cmp_ph(0, `CCC_ST_FD);
    // 65 cycles on plus 76 slow: two steps of 64 cycles taken
    cmp("hyst decay", 12'h005, {6'h00, hyst[5:0]});
    ph_len(0, n);
    cmp_ph(0, `CCC_ST_SD2);
    ph_len(0, n);
    cmp("slow2 len", 12'h04c, n[11:0]);
    cmp_ph(0, `CCC_ST_ON);
  endtask
  // early trips and spikes must be masked for each blanking code
  task automatic t_blank;
    int n;
    logic [11:0] len [4] = '{12'h010, 12'h018, 12'h024, 12'h036};
    rise0 <= 8'h04;
    spike <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      cfg(4'h3, b[1:0], 1'b0, 4'h0);
      wait_ph(0, `CCC_ST_ON);
      ph_len(0, n);
      cmp("on past blank", 12'h001, {11'h000, n[11:0] > len[b]});
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #50 clk_sys = ~clk_sys;
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    t_cot();
    t_nofd();
    t_hyst();
    t_blank();
    complete_run();
  end
  initial begin
    #3000000;
    error_cnt++;
    complete_run();
  end
endmodule // test_coil_current_chopper
